// ---- hdl/asprs_defines.svh ----
// Timing, field and width constants for the converter serial port
`ifndef ASPRS_DEFINES_SVH
`define ASPRS_DEFINES_SVH
`define ASPRS_CLK_HZ 25000000
`define ASPRS_TIMEOUT_MS 28
`define ASPRS_TIMEOUT_CYC ((`ASPRS_CLK_HZ / 1000) * `ASPRS_TIMEOUT_MS)
`define ASPRS_WORD_BITS 16
`define ASPRS_CNT_W 5
`define ASPRS_TMO_W 20
`define ASPRS_CFG_PULLUP 3
`define ASPRS_CFG_MUX_HI 14
`define ASPRS_CFG_MUX_LO 12
`define ASPRS_CFG_NOP_HI 2
`define ASPRS_CFG_NOP_LO 1
`define ASPRS_NOP_VALID 2'h1
`define ASPRS_CFG_RESET 16'h058b
`define ASPRS_SCLK_DIV 8
`define ASPRS_DIV_W 3
`endif

// ---- hdl/asprs_pkg.sv ----
// Types shared by both ends of the converter serial port
package asprs_pkg;
  typedef enum logic [1:0] {
    ASPRS_M_IDLE = 2'b00,
    ASPRS_M_SEL = 2'b01,
    ASPRS_M_SHIFT = 2'b10,
    ASPRS_M_DONE = 2'b11
  } asprs_mstate_t;
  typedef enum logic [2:0] {
    ASPRS_MUX_P0_N1 = 3'b000,
    ASPRS_MUX_P0_N3 = 3'b001,
    ASPRS_MUX_P1_N3 = 3'b010,
    ASPRS_MUX_P2_N3 = 3'b011,
    ASPRS_MUX_P0_GND = 3'b100,
    ASPRS_MUX_P1_GND = 3'b101,
    ASPRS_MUX_P2_GND = 3'b110,
    ASPRS_MUX_P3_GND = 3'b111
  } asprs_mux_t;
endpackage : asprs_pkg

// ---- hdl/asprs_if.sv ----
// Serial link between converter port and its master
`timescale 1ns/1ps
interface asprs_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_o;
  logic dout_oe;
  logic pullup_on;
  logic data_out_ready_n;
  // Wire level: driven, weak high, or floating modelled low
  assign data_out_ready_n = dout_oe ? dout_o : pullup_on;
  modport device (input sclk, input cs_n, input din, input data_out_ready_n, output dout_o, output dout_oe,
    output pullup_on);
  modport host (output sclk, output cs_n, output din, input data_out_ready_n);
endinterface : asprs_if

// ---- hdl/asprs_sync.sv ----
// Two-flop synchroniser with edge detection after the second flop
`timescale 1ns/1ps
module asprs_sync #(
  parameter logic RST_LEVEL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q,
  output logic rise,
  output logic fall
);
  logic meta;
  logic q_d;
  // Capture chain, first flop read only by second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= RST_LEVEL;
      q <= RST_LEVEL;
      q_d <= RST_LEVEL;
    end else begin
      meta <= d;
      q <= meta;
      q_d <= q;
    end
  end
  assign rise = q & ~q_d;
  assign fall = ~q & q_d;
endmodule : asprs_sync

// ---- hdl/asprs_device.sv ----
// Converter end of the serial port: shift, ready flag, output line control
// Contract
// - Mode 1, serial clock idles low
// - Launch on rising edge, capture on falling
// - Clock low over 28 ms aborts transaction
// - Master keeps clock gaps under 28 ms
// - Weak pullup holds line high when deselected
// - Pullup cleared: line floats when deselected
// - No ready indication while deselected
// - Select falling drives line at once
// - Fresh result waiting drives line low
// - No fresh result drives high, old word
// - Mid-transfer result waits for next select
// - Reads never corrupt regardless of conversion
// - Master shares lines, separate selects
// - Master polls by asserting select
// - Single-ended converts one channel against ground
// - First three inputs against fourth input
// - Pullup enable bit 3, resets high
// - Codes 100 to 111 are single-ended
`timescale 1ns/1ps
`include "asprs_defines.svh"
module asprs_device (
  input wire logic clk,
  input wire logic rst,
  asprs_if.device link,
  input wire logic conv_valid,
  input wire logic [`ASPRS_WORD_BITS-1:0] conv_data,
  output logic [`ASPRS_WORD_BITS-1:0] config_word,
  output logic [2:0] mux_select,
  output logic [1:0] mux_pos_input,
  output logic mux_neg_ground,
  output logic timed_out
);
  logic sclk_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_s;
  logic cs_rise;
  logic cs_fall;
  logic din_s;
  logic fresh;
  logic active;
  logic [`ASPRS_WORD_BITS-1:0] result;
  logic [`ASPRS_WORD_BITS-1:0] shift_out;
  logic [`ASPRS_WORD_BITS-1:0] shift_in;
  logic [`ASPRS_CNT_W-1:0] bit_cnt;
  logic [`ASPRS_TMO_W-1:0] low_cnt;
  logic abort;
  logic word_done;
  logic [2:0] mux_route;

  // Synchronised link pins; select chain rests at its idle high
  asprs_sync u_sclk (.clk(clk), .rst(rst), .d(link.sclk), .q(sclk_s), .rise(sclk_rise), .fall(sclk_fall));
  asprs_sync #(.RST_LEVEL(1'b1)) u_cs (.clk(clk), .rst(rst), .d(link.cs_n), .q(cs_s), .rise(cs_rise),
    .fall(cs_fall));
  asprs_sync u_din (.clk(clk), .rst(rst), .d(link.din), .q(din_s), .rise(), .fall());

  // Mux decode: high bit picks ground return
  function automatic logic [2:0] mux_decode(input logic [2:0] code);
    logic [2:0] r;
    r = 3'h0;
    unique case (asprs_pkg::asprs_mux_t'(code))
      asprs_pkg::ASPRS_MUX_P0_N1: r = 3'h0;
      asprs_pkg::ASPRS_MUX_P0_N3: r = 3'h0;
      asprs_pkg::ASPRS_MUX_P1_N3: r = 3'h1;
      asprs_pkg::ASPRS_MUX_P2_N3: r = 3'h2;
      asprs_pkg::ASPRS_MUX_P0_GND: r = 3'h4;
      asprs_pkg::ASPRS_MUX_P1_GND: r = 3'h5;
      asprs_pkg::ASPRS_MUX_P2_GND: r = 3'h6;
      asprs_pkg::ASPRS_MUX_P3_GND: r = 3'h7;
    endcase
    return r;
  endfunction : mux_decode

  // Clock stall watchdog while selected
  assign abort = active & (low_cnt == `ASPRS_TMO_W'(`ASPRS_TIMEOUT_CYC)) & ~sclk_s;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt <= '0;
    end else if (!active || sclk_s) begin
      low_cnt <= '0;
    end else if (low_cnt != `ASPRS_TMO_W'(`ASPRS_TIMEOUT_CYC)) begin
      low_cnt <= low_cnt + `ASPRS_TMO_W'(1);
    end
  end

  // Transaction in progress between select fall and deselect or abort
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active <= 1'b0;
    end else if (cs_fall) begin
      active <= 1'b1;
    end else if (cs_rise || cs_s) begin
      active <= 1'b0;
    end else if (abort) begin
      active <= 1'b0;
    end
  end

  // Stall flag, cleared by the next select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timed_out <= 1'b0;
    end else if (cs_fall) begin
      timed_out <= 1'b0;
    end else if (abort && !cs_s) begin
      timed_out <= 1'b1;
    end
  end

  assign word_done = active & sclk_fall & (bit_cnt == `ASPRS_CNT_W'(`ASPRS_WORD_BITS - 1));

  // Fresh flag: set wins over the clear taken at select fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fresh <= 1'b0;
    end else if (conv_valid) begin
      fresh <= 1'b1;
    end else if (cs_fall && fresh) begin
      fresh <= 1'b0;
    end
  end

  // Latest conversion, kept for repeat reads
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result <= '0;
    end else if (conv_valid) begin
      result <= conv_data;
    end
  end

  // Shift engine: word frozen at select fall, launch on rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_out <= '0;
      bit_cnt <= '0;
    end else if (cs_fall) begin
      shift_out <= (conv_valid ? conv_data : result);
      bit_cnt <= '0;
    end else if (!active) begin
      bit_cnt <= '0;
    end else if (sclk_rise && bit_cnt != '0) begin
      shift_out <= {shift_out[`ASPRS_WORD_BITS-2:0], 1'b0};
    end else if (sclk_fall) begin
      bit_cnt <= word_done ? '0 : bit_cnt + `ASPRS_CNT_W'(1);
    end
  end

  // Capture register, sampled on falling clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_in <= '0;
    end else if (active && sclk_fall) begin
      shift_in <= {shift_in[`ASPRS_WORD_BITS-2:0], din_s};
    end
  end

  // Configuration load on full valid word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_word <= `ASPRS_CFG_RESET;
    end else if (word_done && shift_in[`ASPRS_CFG_NOP_HI-1:`ASPRS_CFG_NOP_LO-1] == `ASPRS_NOP_VALID) begin
      config_word <= {shift_in[`ASPRS_WORD_BITS-2:0], din_s};
    end
  end

  // Route decode of the selector field
  assign mux_route = mux_decode(config_word[`ASPRS_CFG_MUX_HI:`ASPRS_CFG_MUX_LO]);

  // Input selector outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mux_select <= 3'h0;
      mux_pos_input <= 2'h0;
      mux_neg_ground <= 1'b0;
    end else begin
      mux_select <= config_word[`ASPRS_CFG_MUX_HI:`ASPRS_CFG_MUX_LO];
      mux_pos_input <= mux_route[1:0];
      mux_neg_ground <= mux_route[2];
    end
  end

  // Weak pullup follows its configuration bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.pullup_on <= 1'b1;
    end else begin
      link.pullup_on <= config_word[`ASPRS_CFG_PULLUP];
    end
  end

  // Output line: before first clock shows ready, then data; released when deselected
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      link.dout_o <= 1'b1;
      link.dout_oe <= 1'b0;
    end else begin
      if (cs_fall) begin
        link.dout_oe <= 1'b1;
        link.dout_o <= ~(fresh | conv_valid);
      end else if (!active) begin
        link.dout_oe <= 1'b0;
        link.dout_o <= 1'b1;
      end else if (sclk_rise) begin
        link.dout_o <= (bit_cnt == '0) ? shift_out[`ASPRS_WORD_BITS-1] : shift_out[`ASPRS_WORD_BITS-2];
      end
    end
  end
endmodule : asprs_device

// ---- hdl/asprs_host.sv ----
// Master end: divider clock, select, word exchange
`timescale 1ns/1ps
`include "asprs_defines.svh"
module asprs_host (
  input wire logic clk,
  input wire logic rst,
  asprs_if.host link,
  input wire logic start,
  input wire logic [`ASPRS_WORD_BITS-1:0] tx_word,
  output logic busy,
  output logic ready_seen_n,
  output logic [`ASPRS_WORD_BITS-1:0] rx_word,
  output logic rx_valid
);
  asprs_pkg::asprs_mstate_t state;
  logic [`ASPRS_DIV_W-1:0] div;
  logic [`ASPRS_CNT_W-1:0] cnt;
  logic [`ASPRS_WORD_BITS-1:0] tx_sh;
  logic [`ASPRS_WORD_BITS-1:0] rx_sh;
  logic dout_s;
  logic dout_m;
  logic half;
  assign half = (div == `ASPRS_DIV_W'(`ASPRS_SCLK_DIV - 1));

  // Pin synchroniser for the shared line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_m <= 1'b1;
      dout_s <= 1'b1;
    end else begin
      dout_m <= link.data_out_ready_n;
      dout_s <= dout_m;
    end
  end

  // Half period divider
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= '0;
    end else begin
      div <= (half || state == asprs_pkg::ASPRS_M_IDLE) ? '0 : div + `ASPRS_DIV_W'(1);
    end
  end

  // Sequencer: select, poll ready, 16 clocks, deselect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= asprs_pkg::ASPRS_M_IDLE;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.din <= 1'b0;
      cnt <= '0;
      tx_sh <= '0;
      rx_sh <= '0;
      busy <= 1'b0;
      rx_valid <= 1'b0;
      rx_word <= '0;
      ready_seen_n <= 1'b1;
    end else begin
      rx_valid <= 1'b0;
      unique case (state)
        asprs_pkg::ASPRS_M_IDLE: begin
          if (start) begin
            link.cs_n <= 1'b0;
            tx_sh <= tx_word;
            busy <= 1'b1;
            cnt <= '0;
            state <= asprs_pkg::ASPRS_M_SEL;
          end
        end
        asprs_pkg::ASPRS_M_SEL: begin
          if (half) begin
            ready_seen_n <= dout_s;
            state <= asprs_pkg::ASPRS_M_SHIFT;
          end
        end
        asprs_pkg::ASPRS_M_SHIFT: begin
          if (half) begin
            link.sclk <= ~link.sclk;
            if (!link.sclk) begin
              link.din <= tx_sh[`ASPRS_WORD_BITS-1];
              tx_sh <= {tx_sh[`ASPRS_WORD_BITS-2:0], 1'b0};
            end else begin
              rx_sh <= {rx_sh[`ASPRS_WORD_BITS-2:0], dout_s};
              cnt <= cnt + `ASPRS_CNT_W'(1);
              if (cnt == `ASPRS_CNT_W'(`ASPRS_WORD_BITS - 1)) begin
                state <= asprs_pkg::ASPRS_M_DONE;
              end
            end
          end
        end
        asprs_pkg::ASPRS_M_DONE: begin
          if (half) begin
            link.cs_n <= 1'b1;
            busy <= 1'b0;
            rx_word <= rx_sh;
            rx_valid <= 1'b1;
            state <= asprs_pkg::ASPRS_M_IDLE;
          end
        end
      endcase
    end
  end
endmodule : asprs_host

// ---- verification/asprs_props.sv ----
// Concurrent checks on the converter serial link
`timescale 1ns/1ps
module asprs_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic pullup_on,
  input wire logic data_out_ready_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Steps of select, release and clock pulse
  sequence s_drive; ##[2:5] dout_oe; endsequence
  sequence s_release; ##[1:5] !dout_oe; endsequence
  sequence s_pulse; sclk [*8] ##1 !sclk; endsequence
  // Link framing and line ownership
  AST_IDLE_LOW: assert property (cs_n |-> !sclk) else $error("clock high while deselected");
  AST_CS_SETUP: assert property ($fell(cs_n) |-> !sclk [*4]) else $error("clock moved after select");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> s_pulse) else $error("clock pulse width");
  AST_SEL_DRIVE: assert property ($fell(cs_n) |-> s_drive) else $error("line not driven on select");
  AST_DESEL_RELEASE: assert property ($rose(cs_n) |-> s_release) else $error("line held after deselect");
  AST_DESEL_QUIET: assert property (cs_n [*5] |-> !dout_oe && (!pullup_on || data_out_ready_n))
    else $error("line low while deselected");
  AST_LAUNCH_RISE: assert property (dout_oe && $past(dout_oe) && $changed(dout_o) |-> sclk || $past(sclk))
    else $error("data changed away from rising clock");
  AST_PULLUP_RST: assert property ($fell(rst) |-> pullup_on) else $error("pullup off after reset");
endmodule : asprs_props

// ---- verification/adc_serial_port_ready_signalling_tb_top.sv ----
// Bench joining both link ends, with random traffic
`timescale 1ns/1ps
module adc_serial_port_ready_signalling_tb_top;
  logic clk = 1'b0, rst = 1'b1, conv_valid = 1'b0, start = 1'b0;
  logic [15:0] conv_data = 16'h0000, tx_word = 16'h0000, w, old, cfg_word, rx_word;
  logic [2:0] mux_sel;
  logic [1:0] mux_pos;
  logic mux_gnd, t_out, busy, rdy_n, rx_valid;
  int err_total = 0, comparisons = 0, cyc = 0;
  asprs_if asprs_if_inst ();
  asprs_device asprs_device_inst (.clk(clk), .rst(rst), .link(asprs_if_inst), .conv_valid(conv_valid),
    .conv_data(conv_data), .config_word(cfg_word), .mux_select(mux_sel), .mux_pos_input(mux_pos),
    .mux_neg_ground(mux_gnd), .timed_out(t_out));
  asprs_host asprs_host_inst (.clk(clk), .rst(rst), .link(asprs_if_inst), .start(start), .tx_word(tx_word),
    .busy(busy), .ready_seen_n(rdy_n), .rx_word(rx_word), .rx_valid(rx_valid));
  asprs_props asprs_props_inst (.clk(clk), .rst(rst), .sclk(asprs_if_inst.sclk), .cs_n(asprs_if_inst.cs_n),
    .dout_o(asprs_if_inst.dout_o), .dout_oe(asprs_if_inst.dout_oe), .pullup_on(asprs_if_inst.pullup_on),
    .data_out_ready_n(asprs_if_inst.data_out_ready_n));
  // Clock and hang limit
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  // Positive input expected for a selector code
  function automatic logic [1:0] pos(input logic [2:0] m);
    return m[2] ? m[1:0] : (m[1] ? m[1:0] - 2'h1 : 2'h0);
  endfunction : pos
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic conv();
    @(negedge clk);
    conv_data = 16'($urandom);
    conv_valid = 1'b1;
    @(negedge clk);
    conv_valid = 1'b0;
  endtask : conv
  // One host transfer, optional conversion at cycle mid
  task automatic xfer(input logic [15:0] tx, input logic r, input logic [15:0] rx, input int mid);
    int n;
    @(negedge clk);
    tx_word = tx;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
      conv_valid = (n == mid);
      if (n == mid) conv_data = 16'($urandom);
    end
    conv_valid = 1'b0;
    chk("busy", 16'h0, 16'(busy));
    chk("rx_valid", 16'h1, 16'(rx_valid));
    chk("timeout", 16'h0, 16'(t_out));
    chk("ready", 16'(r), 16'(rdy_n));
    chk("rx_word", rx, rx_word);
  endtask : xfer
  task automatic give_verdict();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    void'($urandom(99));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk("config", 16'h058b, cfg_word);
    chk("line", 16'h1, 16'(asprs_if_inst.data_out_ready_n));
    for (int i = 0; i < 8; i++) begin
      conv();
      w = {1'b0, 3'(i), 8'($urandom), 4'hb};
      xfer(w, 1'b0, conv_data, 0);
      chk("config", w, cfg_word);
      chk("mux", 16'(i), 16'(mux_sel));
      chk("pos", 16'(pos(3'(i))), 16'(mux_pos));
      chk("gnd", 16'(i / 4), 16'(mux_gnd));
      xfer(w, 1'b1, conv_data, 0);
    end
    old = conv_data;
    xfer(w, 1'b1, old, 40);
    xfer({w[15:4], 4'h3}, 1'b0, conv_data, 0);
    repeat (8) @(negedge clk);
    chk("line_oe", 16'h0, 16'(asprs_if_inst.dout_oe));
    chk("pullup", 16'h0, 16'(asprs_if_inst.pullup_on));
    chk("line", 16'h0, 16'(asprs_if_inst.data_out_ready_n));
    xfer({w[15:3], 3'h5}, 1'b1, conv_data, 0);
    chk("config", {w[15:4], 4'h3}, cfg_word);
    xfer(w, 1'b1, conv_data, 0);
    repeat (8) @(negedge clk);
    chk("line", 16'h1, 16'(asprs_if_inst.data_out_ready_n));
    give_verdict();
  end
endmodule : adc_serial_port_ready_signalling_tb_top
